// ==== hw/tcc_pkg.sv ====
// Constants and types of the 16-bit capture/compare timer
// Behaviour
// - First match may lag one count clock
// - Lowered cycle value: counter wraps through overflow
// - External trigger ignored during one-shot pulse
// - Either trigger edge clears, starts one-shot
// - Overflow flag on wrap in listed modes
// - Overflow clear ineffective until counter leaves zero
// - Counter read never copies into second register
// - Stopped timer accepts no trigger input
// - One-shot only in free or edge-clear mode
// - Input A as count clock: no capture by A
// - Both edges on A: no cycle register capture
// - Capture at count fall, flag at next rise
// - Rewritten compare may match spuriously
// - Compare-configured register does not capture
// - High input after reset gives immediate rising edge
// - Noise filter samples twice, fx/8 or prescaler
package tcc_pkg;
  localparam int unsigned DW = 16;
  localparam int unsigned AW = 3;
  localparam int unsigned DIV_W = 6;

  typedef enum logic [1:0] {MODE_STOP, MODE_EDGE_CLR, MODE_FREE, MODE_MATCH_CLR} tcc_mode_t;

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets
  localparam logic [AW-1:0] ADDR_CTRL   = 3'h0;
  localparam logic [AW-1:0] ADDR_PRESC  = 3'h1;
  localparam logic [AW-1:0] ADDR_CCCTRL = 3'h2;
  localparam logic [AW-1:0] ADDR_CYCLE_CAPTURE_COMPARE_REG   = 3'h3;
  localparam logic [AW-1:0] ADDR_SECOND_CAPTURE_COMPARE_REG   = 3'h4;
  localparam logic [AW-1:0] ADDR_COUNT  = 3'h5;
  localparam logic [AW-1:0] ADDR_STATUS = 3'h6;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int unsigned CTRL_MODE_LO = 0;
  localparam int unsigned CTRL_MODE_HI = 1;
  localparam int unsigned CTRL_OS_EN   = 2;
  localparam int unsigned CTRL_SOFTWARE_ONESHOT_TRIGGER    = 3;
  localparam int unsigned PRESC_CLK_LO = 0;
  localparam int unsigned PRESC_CLK_HI = 1;
  localparam int unsigned PRESC_ESA_LO = 4;
  localparam int unsigned PRESC_ESA_HI = 5;
  localparam int unsigned PRESC_ESB_LO = 6;
  localparam int unsigned PRESC_ESB_HI = 7;
  localparam int unsigned CC_CYCLE_CAPTURE_COMPARE_REG_CAP  = 0;
  localparam int unsigned CC_CYCLE_CAPTURE_COMPARE_REG_SRCA = 1;
  localparam int unsigned CC_SECOND_CAPTURE_COMPARE_REG_CAP  = 2;
  localparam int unsigned ST_OVF       = 0;
  localparam int unsigned ST_FLAG_A    = 1;
  localparam int unsigned ST_FLAG_B    = 2;
  localparam int unsigned ST_OS_BUSY   = 3;
  localparam int unsigned ST_PULSE     = 4;

  ////////////////////////////////////////////////////////////////////////////
  // Encodings and reset values
  localparam logic [1:0] EDGE_FALL = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_NONE = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;
  localparam logic [1:0] CLK_DIV4  = 2'h0;
  localparam logic [1:0] CLK_DIV16 = 2'h1;
  localparam logic [1:0] CLK_EXT   = 2'h3;
  localparam logic [DIV_W-1:0] MASK_DIV4  = 6'h03;
  localparam logic [DIV_W-1:0] MASK_DIV16 = 6'h0F;
  localparam logic [DIV_W-1:0] MASK_DIV64 = 6'h3F;
  localparam logic [2:0] FILTER_DIV_MASK = 3'h7;
  localparam logic [DW-1:0] COUNT_MAX = 16'hFFFF;
  localparam logic [DW-1:0] RST_WORD  = 16'h0000;
endpackage : tcc_pkg

// ==== hw/tcc_in_filter.sv ====
// Trigger pin synchroniser and two-sample noise filter
`timescale 1ns/1ns
`default_nettype none
module tcc_in_filter
  import tcc_pkg::*;
(
  input  wire logic i_sys_clk,
  input  wire logic i_reset_n,
  input  wire logic i_pin,
  input  wire logic i_sample_en,
  output var  logic o_level
);
  logic sync1;
  logic sync2;
  logic last_sample;

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
    end else begin
      sync1 <= i_pin;
      sync2 <= sync1;
    end
  end

  // Level accepted only after two equal samples
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      last_sample <= 1'b0;
      o_level     <= 1'b0;
    end else if (i_sample_en) begin
      last_sample <= sync2;
      if (sync2 == last_sample) begin
        o_level <= sync2;
      end
    end
  end
endmodule : tcc_in_filter
`default_nettype wire

// ==== hw/tcc_timer16.sv ====
// 16-bit timer/event counter with two capture/compare registers
`timescale 1ns/1ns
`default_nettype none
module tcc_timer16
  import tcc_pkg::*;
(
  input  wire logic          i_sys_clk,
  input  wire logic          i_reset_n,
  input  wire logic [AW-1:0] i_addr,
  input  wire logic [DW-1:0] i_wdata,
  input  wire logic          i_wr,
  input  wire logic          i_rd,
  output var  logic [DW-1:0] o_rdata,
  input  wire logic          i_trigger_input_a,
  input  wire logic          i_trigger_input_b,
  output var  logic          o_pulse_out,
  output var  logic          o_match_capture_irq_a,
  output var  logic          o_match_capture_irq_b
);
  tcc_mode_t        mode;
  logic             oneshot_en;
  logic [1:0]       clk_sel;
  logic [1:0]       edge_sel_a;
  logic [1:0]       edge_sel_b;
  logic             cycle_capture_compare_reg_cap;
  logic             cycle_capture_compare_reg_src_a;
  logic             second_capture_compare_reg_cap;
  logic [DW-1:0]    main_counter;
  logic [DW-1:0]    cycle_capture_compare_reg;
  logic [DW-1:0]    second_capture_compare_reg;
  logic             counter_overflow_flag;
  logic             ovf_hold;
  logic             match_capture_flag_a;
  logic             match_capture_flag_b;
  logic             os_busy;
  logic [DIV_W-1:0] div;
  logic             rise_d;
  logic             ran_once;
  logic [1:0]       lvl;
  logic [1:0]       prev;
  logic [1:0]       edge_acc;
  logic [1:0]       cap_pend;
  logic [1:0]       flag_pend;
  logic             run;
  logic             ext_clk;
  logic             presc_rise;
  logic             presc_fall;
  logic             sample_en;
  logic             count_rise;
  logic             count_fall;
  logic             wr_ctrl;
  logic             wr_cycle_capture_compare_reg;
  logic             wr_second_capture_compare_reg;
  logic             wr_status;
  logic             software_oneshot_trigger;
  logic             os_ok;
  logic             os_start;
  logic             clr_start;
  logic             match_a_evt;
  logic             match_b_evt;
  logic             ovf_evt;
  logic             req_a;
  logic             req_b;
  logic [1:0]       cap_fire;
  logic             set_a;
  logic             set_b;
  logic [DW-1:0]    next_counter;
  logic [DW-1:0]    next_rdata;

  ////////////////////////////////////////////////////////////////////////////
  // Decoding helpers
  function automatic logic edge_hit(input logic p, input logic l, input logic [1:0] sel);
    edge_hit = (l != p) && (sel == EDGE_BOTH || (sel == EDGE_RISE && l) ||
               (sel == EDGE_FALL && !l));
  endfunction : edge_hit

  function automatic logic div_phase(input logic [DIV_W-1:0] d, input logic [1:0] sel,
                                     input logic half);
    logic [DIV_W-1:0] mask;
    mask = (sel == CLK_DIV4) ? MASK_DIV4 : (sel == CLK_DIV16) ? MASK_DIV16 : MASK_DIV64;
    div_phase = half ? ((d & mask) == ((mask >> 1) + 6'h01)) : ((d & mask) == 6'h00);
  endfunction : div_phase

  ////////////////////////////////////////////////////////////////////////////
  // Count clock and sampling clock
  assign run        = (mode != MODE_STOP);
  assign ext_clk    = (clk_sel == CLK_EXT);
  assign presc_rise = !ext_clk && div_phase(div, clk_sel, 1'b0);
  assign presc_fall = !ext_clk && div_phase(div, clk_sel, 1'b1);
  assign sample_en  = ext_clk ? (div[2:0] == FILTER_DIV_MASK) : presc_rise;
  assign count_rise = ext_clk ? edge_acc[0] : presc_rise;
  assign count_fall = ext_clk ? rise_d : presc_fall;

  // Divider runs free, so a start lands anywhere in a count period
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      div    <= '0;
      rise_d <= 1'b0;
    end else begin
      div    <= div + 6'h01;
      rise_d <= count_rise;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Trigger inputs: filter and edge detection
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_in
      tcc_in_filter u_filt (
        .i_sys_clk   (i_sys_clk),
        .i_reset_n   (i_reset_n),
        .i_pin       ((gi == 0) ? i_trigger_input_a : i_trigger_input_b),
        .i_sample_en (sample_en),
        .o_level     (lvl[gi])
      );
    end
  endgenerate

  assign edge_acc[0] = run && edge_hit(prev[0], lvl[0], edge_sel_a);
  assign edge_acc[1] = run && edge_hit(prev[1], lvl[1], edge_sel_b);

  // Before the first start prev stays low, afterwards it tracks the level
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ran_once <= 1'b0;
      prev     <= 2'b00;
    end else begin
      ran_once <= ran_once | run;
      if (run || ran_once) begin
        prev <= lvl;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Counter, matches and overflow
  assign software_oneshot_trigger = wr_ctrl && i_wdata[CTRL_SOFTWARE_ONESHOT_TRIGGER];
  assign os_ok = oneshot_en && (mode == MODE_FREE || mode == MODE_EDGE_CLR);
  assign os_start = os_ok && !os_busy &&
                    (software_oneshot_trigger || edge_acc[0] || edge_acc[1]);
  assign clr_start = os_start || (mode == MODE_EDGE_CLR && !os_ok && edge_acc[0]);
  assign match_a_evt = run && count_rise && !cycle_capture_compare_reg_cap &&
                       (main_counter == cycle_capture_compare_reg);
  assign match_b_evt = run && count_rise && !second_capture_compare_reg_cap &&
                       (main_counter == second_capture_compare_reg);
  assign ovf_evt = run && count_rise && !clr_start && (main_counter == COUNT_MAX) &&
                   (mode != MODE_MATCH_CLR || cycle_capture_compare_reg == COUNT_MAX);

  always_comb begin
    next_counter = main_counter;
    if (!run) begin
      next_counter = RST_WORD;
    end else if (clr_start) begin
      next_counter = RST_WORD;
    end else if (count_rise) begin
      if (mode == MODE_MATCH_CLR && match_a_evt) begin
        next_counter = RST_WORD;
      end else begin
        next_counter = main_counter + 16'h0001;
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      main_counter <= RST_WORD;
    end else begin
      main_counter <= next_counter;
    end
  end

  // Clear is refused while the counter still sits at zero after a wrap
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      counter_overflow_flag <= 1'b0;
      ovf_hold              <= 1'b0;
    end else begin
      if (ovf_evt) begin
        ovf_hold <= 1'b1;
      end else if (!run || next_counter != RST_WORD) begin
        ovf_hold <= 1'b0;
      end
      if (ovf_evt || ovf_hold) begin
        counter_overflow_flag <= 1'b1;
      end else if (wr_status && i_wdata[ST_OVF]) begin
        counter_overflow_flag <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // One-shot pulse
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      os_busy     <= 1'b0;
      o_pulse_out <= 1'b0;
    end else if (!os_ok) begin
      os_busy     <= 1'b0;
      o_pulse_out <= 1'b0;
    end else if (os_start) begin
      os_busy     <= 1'b1;
      o_pulse_out <= 1'b0;
    end else if (os_busy && match_a_evt) begin
      os_busy     <= 1'b0;
      o_pulse_out <= 1'b0;
    end else if (os_busy && match_b_evt) begin
      o_pulse_out <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Capture: latched at count fall, flagged at next count rise
  assign req_b = second_capture_compare_reg_cap && edge_acc[0] && !ext_clk;
  assign req_a = cycle_capture_compare_reg_cap && (edge_sel_a != EDGE_BOTH) &&
                 (cycle_capture_compare_reg_src_a ? (edge_acc[0] && !ext_clk) : edge_acc[1]);
  assign cap_fire = cap_pend & {2{count_fall}};

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cap_pend  <= 2'b00;
      flag_pend <= 2'b00;
    end else if (!run) begin
      cap_pend  <= 2'b00;
      flag_pend <= 2'b00;
    end else begin
      cap_pend  <= (cap_pend & ~cap_fire) | {req_b, req_a};
      flag_pend <= (flag_pend & ~{2{count_rise}}) | cap_fire;
    end
  end

  assign set_a = match_a_evt || (flag_pend[0] && count_rise);
  assign set_b = match_b_evt || (flag_pend[1] && count_rise);

  // Capture beats a software write in the same cycle
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cycle_capture_compare_reg  <= RST_WORD;
      second_capture_compare_reg <= RST_WORD;
    end else begin
      if (cap_fire[0]) begin
        cycle_capture_compare_reg <= main_counter;
      end else if (wr_cycle_capture_compare_reg) begin
        cycle_capture_compare_reg <= i_wdata;
      end
      if (cap_fire[1]) begin
        second_capture_compare_reg <= main_counter;
      end else if (wr_second_capture_compare_reg) begin
        second_capture_compare_reg <= i_wdata;
      end
    end
  end

  // Flags: set wins over clear
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      match_capture_flag_a  <= 1'b0;
      match_capture_flag_b  <= 1'b0;
      o_match_capture_irq_a <= 1'b0;
      o_match_capture_irq_b <= 1'b0;
    end else begin
      o_match_capture_irq_a <= set_a;
      o_match_capture_irq_b <= set_b;
      if (set_a) begin
        match_capture_flag_a <= 1'b1;
      end else if (wr_status && i_wdata[ST_FLAG_A]) begin
        match_capture_flag_a <= 1'b0;
      end
      if (set_b) begin
        match_capture_flag_b <= 1'b1;
      end else if (wr_status && i_wdata[ST_FLAG_B]) begin
        match_capture_flag_b <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register port
  assign wr_ctrl   = i_wr && (i_addr == ADDR_CTRL);
  assign wr_cycle_capture_compare_reg   = i_wr && (i_addr == ADDR_CYCLE_CAPTURE_COMPARE_REG);
  assign wr_second_capture_compare_reg   = i_wr && (i_addr == ADDR_SECOND_CAPTURE_COMPARE_REG);
  assign wr_status = i_wr && (i_addr == ADDR_STATUS);

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      mode       <= MODE_STOP;
      oneshot_en <= 1'b0;
      clk_sel    <= CLK_DIV4;
      edge_sel_a <= EDGE_FALL;
      edge_sel_b <= EDGE_FALL;
      cycle_capture_compare_reg_cap   <= 1'b0;
      cycle_capture_compare_reg_src_a <= 1'b0;
      second_capture_compare_reg_cap   <= 1'b0;
    end else if (i_wr) begin
      if (i_addr == ADDR_CTRL) begin
        mode       <= tcc_mode_t'(i_wdata[CTRL_MODE_HI:CTRL_MODE_LO]);
        oneshot_en <= i_wdata[CTRL_OS_EN];
      end
      if (i_addr == ADDR_PRESC) begin
        clk_sel    <= i_wdata[PRESC_CLK_HI:PRESC_CLK_LO];
        edge_sel_a <= i_wdata[PRESC_ESA_HI:PRESC_ESA_LO];
        edge_sel_b <= i_wdata[PRESC_ESB_HI:PRESC_ESB_LO];
      end
      if (i_addr == ADDR_CCCTRL) begin
        cycle_capture_compare_reg_cap   <= i_wdata[CC_CYCLE_CAPTURE_COMPARE_REG_CAP];
        cycle_capture_compare_reg_src_a <= i_wdata[CC_CYCLE_CAPTURE_COMPARE_REG_SRCA];
        second_capture_compare_reg_cap   <= i_wdata[CC_SECOND_CAPTURE_COMPARE_REG_CAP];
      end
    end
  end

  always_comb begin
    next_rdata = RST_WORD;
    unique case (i_addr)
      ADDR_CTRL:   next_rdata = {13'h0000, oneshot_en, mode};
      ADDR_PRESC:  next_rdata = {8'h00, edge_sel_b, edge_sel_a, 2'h0, clk_sel};
      ADDR_CCCTRL: next_rdata = {13'h0000, second_capture_compare_reg_cap, cycle_capture_compare_reg_src_a, cycle_capture_compare_reg_cap};
      ADDR_CYCLE_CAPTURE_COMPARE_REG:   next_rdata = cycle_capture_compare_reg;
      ADDR_SECOND_CAPTURE_COMPARE_REG:   next_rdata = second_capture_compare_reg;
      ADDR_COUNT:  next_rdata = main_counter;
      ADDR_STATUS: next_rdata = {11'h000, o_pulse_out, os_busy, match_capture_flag_b,
                                 match_capture_flag_a, counter_overflow_flag};
      default:     next_rdata = RST_WORD;
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_rdata <= RST_WORD;
    end else begin
      o_rdata <= i_rd ? next_rdata : RST_WORD;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  AST_COUNT_INC: assert property (
    @(posedge i_sys_clk) disable iff (!i_reset_n)
    (run && count_rise && !clr_start && !(mode == MODE_MATCH_CLR && match_a_evt))
    |=> (main_counter == $past(main_counter) + 16'h0001))
    else $error("counter did not advance on count tick");
  AST_STOP_NO_INPUT: assert property (
    @(posedge i_sys_clk) disable iff (!i_reset_n)
    !run |-> (edge_acc == 2'b00) ##1 (main_counter == RST_WORD))
    else $error("stopped timer accepted input or kept count");
  AST_OVF_SET: assert property (
    @(posedge i_sys_clk) disable iff (!i_reset_n)
    (run && count_rise && !clr_start && main_counter == COUNT_MAX && mode != MODE_MATCH_CLR)
    |=> counter_overflow_flag && main_counter == RST_WORD)
    else $error("overflow flag not set on wrap");
  AST_OVF_CLR_LOST: assert property (
    @(posedge i_sys_clk) disable iff (!i_reset_n)
    (ovf_hold && wr_status && i_wdata[ST_OVF]) |=> counter_overflow_flag)
    else $error("overflow clear took effect at count zero");
  AST_OS_IGNORE: assert property (
    @(posedge i_sys_clk) disable iff (!i_reset_n)
    (os_busy && os_ok && edge_acc[0] && !count_rise) |=> $stable(main_counter))
    else $error("trigger restarted a running one-shot");
  AST_OS_MATCH_MODE: assert property (
    @(posedge i_sys_clk) disable iff (!i_reset_n)
    (mode == MODE_MATCH_CLR) |=> !os_busy && !o_pulse_out)
    else $error("one-shot active in match-clear mode");
  AST_NO_CAP_BOTH: assert property (
    @(posedge i_sys_clk) disable iff (!i_reset_n)
    (edge_sel_a == EDGE_BOTH && cycle_capture_compare_reg_src_a && !wr_cycle_capture_compare_reg) |-> !req_a ##1 1'b1)
    else $error("cycle register capture with both edges");
  AST_NO_CAP_EXT: assert property (
    @(posedge i_sys_clk) disable iff (!i_reset_n)
    (ext_clk && edge_acc[0]) |-> !req_b && !(cycle_capture_compare_reg_src_a && req_a))
    else $error("capture by input used as count clock");
  AST_CAP_FLAG_RISE: assert property (
    @(posedge i_sys_clk) disable iff (!i_reset_n)
    (run && cap_fire[1]) |-> count_fall ##1 flag_pend[1])
    else $error("capture not at count fall or flag lost");
endmodule : tcc_timer16
`default_nettype wire

// ==== bench/tcc_trig_src.sv ====
// Trigger pin sources driven toward the capture/compare timer
`timescale 1ns/1ns
`default_nettype none
module tcc_trig_src (
  input  wire logic i_sys_clk,
  output var  logic o_trig_a,
  output var  logic o_trig_b
);
  initial begin
    o_trig_a = 1'b1;
    o_trig_b = 1'b0;
  end

  task automatic set_a(input logic lvl);
    @(posedge i_sys_clk);
    o_trig_a <= lvl;
  endtask : set_a

  task automatic pulse_a(input int hi, input int lo);
    set_a(1'b1);
    repeat (hi) @(posedge i_sys_clk);
    set_a(1'b0);
    repeat (lo) @(posedge i_sys_clk);
  endtask : pulse_a
endmodule : tcc_trig_src
`default_nettype wire

// ==== bench/tb_timer16_capture_compare_rules.sv ====
// Self-checking bench of the capture/compare timer
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, ex, gt) begin \
  num_checks++; \
  if ((gt) !== (ex)) begin \
    mismatches++; \
    $display("CHECK FAILED %s exp=%h got=%h", nm, ex, gt); \
  end \
end
module tb_timer16_capture_compare_rules;
  import tcc_pkg::*;
  logic          i_sys_clk;
  logic          i_reset_n;
  logic [AW-1:0] i_addr;
  logic [DW-1:0] i_wdata;
  logic          i_wr;
  logic          i_rd;
  logic [DW-1:0] o_rdata;
  logic          trig_a;
  logic          trig_b;
  logic          o_pulse_out;
  logic          irq_a;
  logic          irq_b;
  int            mismatches;
  int            num_checks;
  int            cyc_n;
  int            irq_a_n;
  int            irq_b_n;
  int            pulse_hi;

  tcc_timer16 u_tcc_timer16 (.i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_trigger_input_a(trig_a), .i_trigger_input_b(trig_b), .o_pulse_out(o_pulse_out),
    .o_match_capture_irq_a(irq_a), .o_match_capture_irq_b(irq_b));
  tcc_trig_src u_tcc_trig_src (.i_sys_clk(i_sys_clk), .o_trig_a(trig_a), .o_trig_b(trig_b));

  ////////////////////////////////////////////////////////////////////////////
  // Clock, event counters, timeout
  initial i_sys_clk = 1'b0;
  always #50 i_sys_clk = ~i_sys_clk;

  always @(posedge i_sys_clk) begin
    cyc_n++;
    if (irq_a === 1'b1) irq_a_n++;
    if (irq_b === 1'b1) irq_b_n++;
    if (o_pulse_out === 1'b1) pulse_hi++;
    if (cyc_n == 30000) begin
      mismatches++;
      tally_and_finish();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus tasks and expectations
  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge i_sys_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_sys_clk);
    i_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [AW-1:0] a, output logic [DW-1:0] d);
    @(posedge i_sys_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_sys_clk);
    i_rd <= 1'b0;
    #1;
    d = o_rdata;
  endtask : rd

  task automatic cyc(input int n);
    repeat (n) @(posedge i_sys_clk);
  endtask : cyc

  function automatic logic [DW-1:0] presc(input logic [1:0] ea, input logic [1:0] ck);
    presc = 16'h0000;
    presc[PRESC_ESA_HI:PRESC_ESA_LO] = ea;
    presc[PRESC_ESB_HI:PRESC_ESB_LO] = EDGE_NONE;
    presc[PRESC_CLK_HI:PRESC_CLK_LO] = ck;
  endfunction : presc

  function automatic int period(input int cr);
    period = (cr + 1) * 4;
  endfunction : period

  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : tally_and_finish

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    logic [DW-1:0] v;
    logic [DW-1:0] t0;
    logic [DW-1:0] t1;
    int            n;
    int            cr;
    i_reset_n = 1'b0;
    i_addr = '0;
    i_wdata = '0;
    i_wr = 1'b0;
    i_rd = 1'b0;
    void'($urandom(70));
    cyc(20);
    i_reset_n <= 1'b1;
    wr(3'h7, 16'hFFFF);
    for (int a = 0; a < 8; a++) begin
      rd(a[AW-1:0], v);
      `CHK("reset_read", 16'h0000, v)
    end
    // High pin right after reset, then restart
    wr(ADDR_PRESC, presc(EDGE_RISE, CLK_DIV4));
    wr(ADDR_CCCTRL, 16'h0004);
    wr(ADDR_CYCLE_CAPTURE_COMPARE_REG, 16'h0100);
    wr(ADDR_CTRL, 16'h0002);
    cyc(60);
    `CHK("irq_b_first_start", 1, irq_b_n)
    wr(ADDR_CTRL, 16'h0000);
    wr(ADDR_CTRL, 16'h0002);
    cyc(60);
    `CHK("irq_b_restart", 1, irq_b_n)
    u_tcc_trig_src.set_a(1'b0);
    cyc(40);
    rd(ADDR_COUNT, t0);
    cyc(38);
    rd(ADDR_COUNT, t1);
    `CHK("count_step", 16'(40 / 4), 16'(t1 - t0))
    // Random captures into the second register
    for (int i = 0; i < 4; i++) begin
      n = irq_b_n;
      rd(ADDR_COUNT, t0);
      cyc($urandom_range(15, 0));
      u_tcc_trig_src.pulse_a(12 + $urandom_range(20, 0), 30);
      rd(ADDR_COUNT, t1);
      rd(ADDR_SECOND_CAPTURE_COMPARE_REG, v);
      `CHK("cap_irq_b_count", n + 1, irq_b_n)
      `CHK("cap_in_window", 1'b1, (v >= t0 && v <= t1))
    end
    `CHK("no_match_a_below_cycle_capture_compare_reg", 0, irq_a_n)
    `CHK("no_pulse_without_oneshot", 0, pulse_hi)
    tally_and_finish();
  end
endmodule : tb_timer16_capture_compare_rules
`default_nettype wire
